// ### logic/spf_pkg.sv
// Constants for the system pin function block
//
// Contract
// R01 - Second external interrupt is edge triggered, polarity chosen by software.
// R02 - Interrupt source holds new level at least one clock after edge.
// R03 - Interrupt pin also serves as converter start trigger or GPIO.
// R04 - Flag pin driven by latch set and cleared by instructions.
// R05 - Reset makes the flag pin the flag output; software may choose GPIO.
// R06 - Conditional branch taken when branch input low, not when high.
// R07 - Board pulls unused branch input high.
// R08 - Reset makes branch pin the branch input; software may choose GPIO.
// R09 - Clock pin carries CPU or watchdog clock, chosen by select bit 14.
// R10 - Clock pin usable as GPIO; it leaves reset as an output.
// R11 - Oscillator output goes high impedance while emulator off is low.
// R12 - Interrupt input synchronised, edge detected, one request per edge.
package spf_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_GPIO_DIR = 4'h1;
  localparam logic [3:0] ADDR_GPIO_OUT = 4'h2;
  localparam logic [3:0] ADDR_GPIO_IN = 4'h3;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  // Control register fields
  localparam int CTRL_POL_RISE = 0;
  localparam int CTRL_IRQ_FN = 1;
  localparam int CTRL_SOC_FN = 2;
  localparam int CTRL_FLAG_GPIO = 3;
  localparam int CTRL_BRANCH_GPIO = 4;
  localparam int CTRL_CLK_GPIO = 5;
  localparam logic [15:0] CTRL_RST = 16'h0002;
  // Select bit inside the system status and control register
  localparam int SYS_CLOCK_OUT_SELECT = 14;
  localparam logic [15:0] SYS_CTRL_RST = 16'h0000;
  // GPIO bit numbers: 0 irq pin, 1 flag pin, 2 branch pin, 3 clock pin
  localparam int GP_IRQ = 0;
  localparam int GP_FLAG = 1;
  localparam int GP_BRANCH = 2;
  localparam int GP_CLK = 3;
  localparam logic [3:0] GPIO_DIR_RST = 4'h0;
  localparam logic [3:0] GPIO_OUT_RST = 4'h0;
  // Status bits
  localparam int ST_IRQ = 0;
  localparam int ST_SOC = 1;
  localparam logic [1:0] STAT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
endpackage : spf_pkg

// ### logic/spf_system_pins.sv
// System pin functions: interrupt pin, flag, branch input, clock out
`timescale 1ns/1ns
module spf_system_pins (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic flag_set_instr_in,
  input wire logic flag_clear_instr_in,
  input wire logic cond_branch_instr_in,
  output logic branch_taken_out,
  input wire logic watchdog_clock_in,
  input wire logic emu_off_n_in,
  input wire logic osc_drive_in,
  output logic osc_output_out,
  output logic osc_output_oe_n_out,
  input wire logic ext_irq_two_pin_in,
  output logic ext_irq_two_pin_out,
  output logic ext_irq_two_pin_oe_n_out,
  input wire logic flag_pin_in,
  output logic flag_pin_out,
  output logic flag_pin_oe_n_out,
  input wire logic branch_pin_in,
  output logic branch_pin_out,
  output logic branch_pin_oe_n_out,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_n_out,
  output logic ext_irq_two_req_out,
  output logic conv_start_trigger_out,
  output logic irq_out
);
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] sys_ctrl_q, sys_ctrl_d;
  logic [3:0] dir_q, dir_d;
  logic [3:0] gout_q, gout_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic [15:0] rdata_q, rdata_d;
  logic flag_q, flag_d;
  logic sync1_q, sync2_q, last_q;
  logic req_q, req_d, soc_q, soc_d, br_q, br_d;
  logic edge_seen;
  logic [3:0] pin_in;

  // Synchroniser; the first stage feeds only the second
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sync1_q <= ext_irq_two_pin_in;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end

  // R01 selected edge polarity
  // R12 one pulse per edge
  assign edge_seen = ctrl_q[spf_pkg::CTRL_POL_RISE] ? (sync2_q & ~last_q)
                                                    : (~sync2_q & last_q);

  assign pin_in = {clk_pin_in, branch_pin_in, flag_pin_in, ext_irq_two_pin_in};

  // Next state of registers, latch and event pulses
  always_comb begin
    ctrl_d = ctrl_q;
    sys_ctrl_d = sys_ctrl_q;
    dir_d = dir_q;
    gout_d = gout_q;
    mask_d = mask_q;
    stat_d = stat_q;
    flag_d = flag_q;
    rdata_d = 16'h0000;
    // R03 interrupt or converter start function
    req_d = edge_seen & ctrl_q[spf_pkg::CTRL_IRQ_FN];
    soc_d = edge_seen & ctrl_q[spf_pkg::CTRL_SOC_FN];
    // R06 branch when input low
    br_d = cond_branch_instr_in & ~branch_pin_in &
           ~ctrl_q[spf_pkg::CTRL_BRANCH_GPIO];
    // R04 instruction driven latch
    if (flag_set_instr_in) begin
      flag_d = 1'b1;
    end else if (flag_clear_instr_in) begin
      flag_d = 1'b0;
    end
    if (wr_in) begin
      case (addr_in)
        spf_pkg::ADDR_CTRL: ctrl_d = wdata_in;
        spf_pkg::ADDR_GPIO_DIR: dir_d = wdata_in[3:0];
        spf_pkg::ADDR_GPIO_OUT: gout_d = wdata_in[3:0];
        spf_pkg::ADDR_SYS_CTRL: sys_ctrl_d = wdata_in;
        spf_pkg::ADDR_IRQ_STAT: stat_d = stat_q & ~wdata_in[1:0];
        spf_pkg::ADDR_IRQ_MASK: mask_d = wdata_in[1:0];
        default: ;
      endcase
    end
    // Events win over a clear in the same cycle
    if (req_d) begin
      stat_d[spf_pkg::ST_IRQ] = 1'b1;
    end
    if (soc_d) begin
      stat_d[spf_pkg::ST_SOC] = 1'b1;
    end
    if (rd_in) begin
      case (addr_in)
        spf_pkg::ADDR_CTRL: rdata_d = ctrl_q;
        spf_pkg::ADDR_GPIO_DIR: rdata_d = {12'h000, dir_q};
        spf_pkg::ADDR_GPIO_OUT: rdata_d = {12'h000, gout_q};
        spf_pkg::ADDR_GPIO_IN: rdata_d = {12'h000, pin_in};
        spf_pkg::ADDR_SYS_CTRL: rdata_d = sys_ctrl_q;
        spf_pkg::ADDR_IRQ_STAT: rdata_d = {14'h0000, stat_q};
        spf_pkg::ADDR_IRQ_MASK: rdata_d = {14'h0000, mask_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // R05 flag pin defaults to flag output
  // R08 branch pin defaults to branch input
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= spf_pkg::CTRL_RST;
      sys_ctrl_q <= spf_pkg::SYS_CTRL_RST;
      dir_q <= spf_pkg::GPIO_DIR_RST;
      gout_q <= spf_pkg::GPIO_OUT_RST;
      stat_q <= spf_pkg::STAT_RST;
      mask_q <= spf_pkg::MASK_RST;
      rdata_q <= 16'h0000;
      flag_q <= 1'b0;
      req_q <= 1'b0;
      soc_q <= 1'b0;
      br_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      sys_ctrl_q <= sys_ctrl_d;
      dir_q <= dir_d;
      gout_q <= gout_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      flag_q <= flag_d;
      req_q <= req_d;
      soc_q <= soc_d;
      br_q <= br_d;
    end
  end

  assign rdata_out = rdata_q;
  assign ext_irq_two_req_out = req_q;
  assign conv_start_trigger_out = soc_q;
  assign branch_taken_out = br_q;
  assign irq_out = |(stat_q & mask_q);

  // Interrupt pin: input unless both functions off and GPIO output chosen
  assign ext_irq_two_pin_out = gout_q[spf_pkg::GP_IRQ];
  assign ext_irq_two_pin_oe_n_out = ctrl_q[spf_pkg::CTRL_IRQ_FN] |
                                    ctrl_q[spf_pkg::CTRL_SOC_FN] |
                                    ~dir_q[spf_pkg::GP_IRQ];

  // R04 flag pin driven from latch
  // R05 GPIO only when software chooses
  assign flag_pin_out = ctrl_q[spf_pkg::CTRL_FLAG_GPIO] ? gout_q[spf_pkg::GP_FLAG] : flag_q;
  assign flag_pin_oe_n_out = ctrl_q[spf_pkg::CTRL_FLAG_GPIO] & ~dir_q[spf_pkg::GP_FLAG];

  // R08 branch pin input unless GPIO output chosen
  assign branch_pin_out = gout_q[spf_pkg::GP_BRANCH];
  assign branch_pin_oe_n_out = ~(ctrl_q[spf_pkg::CTRL_BRANCH_GPIO] & dir_q[spf_pkg::GP_BRANCH]);

  // R09 clock source select
  // R10 GPIO mode, output at reset
  assign clk_pin_out = ctrl_q[spf_pkg::CTRL_CLK_GPIO] ? gout_q[spf_pkg::GP_CLK] :
                       (sys_ctrl_q[spf_pkg::SYS_CLOCK_OUT_SELECT] ? watchdog_clock_in : clock_in);
  assign clk_pin_oe_n_out = ctrl_q[spf_pkg::CTRL_CLK_GPIO] & ~dir_q[spf_pkg::GP_CLK];

  // R11 oscillator output released while emulator off low
  assign osc_output_out = osc_drive_in;
  assign osc_output_oe_n_out = ~emu_off_n_in;
endmodule : spf_system_pins

// ### tb/spf_board.sv
// Board side: interrupt source and pulled-up branch line
`timescale 1ns/1ns
module spf_board (
  input wire logic irq_lvl_in,
  input wire logic br_lvl_in,
  output logic irq_pin_out,
  output logic br_pin_out
);
  // source holds each level for cycles
  assign irq_pin_out = irq_lvl_in;
  // line pulled high unless driven low
  assign br_pin_out = br_lvl_in;
endmodule : spf_board

// ### tb/spf_props.sv
// Checker for the system pin block
`timescale 1ns/1ns
module spf_props (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic flag_set_instr_in,
  input wire logic flag_clear_instr_in,
  input wire logic cond_branch_instr_in,
  input wire logic branch_pin_in,
  input wire logic branch_taken_out,
  input wire logic emu_off_n_in,
  input wire logic osc_output_oe_n_out,
  input wire logic flag_pin_out,
  input wire logic ext_irq_two_pin_in,
  input wire logic ext_irq_two_req_out,
  input wire logic conv_start_trigger_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  AST_BR_HIGH: assert property (cond_branch_instr_in && branch_pin_in |=> !branch_taken_out)
    else $error("branch taken with input high");
  AST_BR_CAUSE: assert property (
    branch_taken_out |-> $past(cond_branch_instr_in) && !$past(branch_pin_in))
    else $error("branch without low input");
  AST_OSC_OFF: assert property (!emu_off_n_in |-> osc_output_oe_n_out)
    else $error("oscillator output driven while off");
  AST_FLAG_SET: assert property (flag_set_instr_in |=> flag_pin_out)
    else $error("flag not set");
  AST_FLAG_CLR: assert property (flag_clear_instr_in && !flag_set_instr_in |=> !flag_pin_out)
    else $error("flag not cleared");
  AST_REQ_ONE: assert property (ext_irq_two_req_out |=> !ext_irq_two_req_out)
    else $error("request longer than one cycle");
  AST_REQ_CAUSE: assert property (
    ext_irq_two_req_out |-> $past(ext_irq_two_pin_in, 3) != $past(ext_irq_two_pin_in, 4))
    else $error("request without pin edge");
  AST_SOC_CAUSE: assert property (
    conv_start_trigger_out |-> $past(ext_irq_two_pin_in, 3) != $past(ext_irq_two_pin_in, 4))
    else $error("trigger without pin edge");
endmodule : spf_props
bind spf_system_pins spf_props i_props (.clock_in, .rst_b_in, .flag_set_instr_in,
  .flag_clear_instr_in, .cond_branch_instr_in, .branch_pin_in, .branch_taken_out,
  .emu_off_n_in, .osc_output_oe_n_out, .flag_pin_out, .ext_irq_two_pin_in,
  .ext_irq_two_req_out, .conv_start_trigger_out);

// ### tb/tb.sv
// Self-checking bench for the system pin block
`timescale 1ns/1ns
module tb;
  logic clock_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq_lvl = 1'b0;
  logic flag_set_instr_in = 1'b0, flag_clear_instr_in = 1'b0, cond_branch_instr_in = 1'b0;
  logic watchdog_clock_in = 1'b0, emu_off_n_in = 1'b1, osc_drive_in = 1'b0, br_lvl = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000, rdata_out, v;
  logic branch_taken_out, osc_output_out, osc_output_oe_n_out, ext_irq_two_pin_in;
  logic ext_irq_two_pin_out, ext_irq_two_pin_oe_n_out, flag_pin_out, flag_pin_oe_n_out;
  logic branch_pin_in, branch_pin_out, branch_pin_oe_n_out, clk_pin_out, clk_pin_oe_n_out;
  logic ext_irq_two_req_out, conv_start_trigger_out, irq_out;
  logic [31:0] seed = 32'hD3A4AB03;
  int n_fail = 0, num_checks = 0, n_req = 0, n_soc = 0, n_exp = 0;
  spf_system_pins i_dut (.clock_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .flag_set_instr_in, .flag_clear_instr_in, .cond_branch_instr_in, .branch_taken_out,
    .watchdog_clock_in, .emu_off_n_in, .osc_drive_in, .osc_output_out, .osc_output_oe_n_out,
    .ext_irq_two_pin_in, .ext_irq_two_pin_out, .ext_irq_two_pin_oe_n_out,
    .flag_pin_in(flag_pin_oe_n_out | flag_pin_out), .flag_pin_out, .flag_pin_oe_n_out,
    .branch_pin_in, .branch_pin_out, .branch_pin_oe_n_out,
    .clk_pin_in(clk_pin_oe_n_out | clk_pin_out), .clk_pin_out, .clk_pin_oe_n_out,
    .ext_irq_two_req_out, .conv_start_trigger_out, .irq_out);
  spf_board i_board (.irq_lvl_in(irq_lvl), .br_lvl_in(br_lvl),
    .irq_pin_out(ext_irq_two_pin_in), .br_pin_out(branch_pin_in));
  always #10 clock_in = ~clock_in;
  // Count request and trigger pulses
  always @(posedge clock_in) begin
    if (ext_irq_two_req_out === 1'b1) n_req++;
    if (conv_start_trigger_out === 1'b1) n_soc++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic int qual(input logic a, input logic b, input logic rise);
    return int'(a != b && b == rise);
  endfunction : qual
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in) wr_in <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in) rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd_reg
  task automatic finish_test;
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in) #1 chk({flag_pin_oe_n_out, flag_pin_out}, 16'h0);
    chk({branch_pin_oe_n_out, clk_pin_oe_n_out}, 16'h2);
    @(posedge clock_in) flag_set_instr_in <= 1'b1;
    @(posedge clock_in) flag_set_instr_in <= 1'b0;
    #1 chk(flag_pin_out, 16'h1);
    @(posedge clock_in) flag_clear_instr_in <= 1'b1;
    @(posedge clock_in) flag_clear_instr_in <= 1'b0;
    #1 chk(flag_pin_out, 16'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in) br_lvl <= i[0];
      cond_branch_instr_in <= 1'b1;
      @(posedge clock_in) cond_branch_instr_in <= 1'b0;
      #1 chk(branch_taken_out, !br_lvl);
    end
    br_lvl <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      wr_reg(spf_pkg::ADDR_IRQ_MASK, 16'h0003);
      wr_reg(spf_pkg::ADDR_CTRL, 16'h0006 | 16'(r));
      n_req = 0;
      n_soc = 0;
      n_exp = 0;
      repeat (12) begin
        seed = xs(seed);
        n_exp += qual(irq_lvl, seed[0], r[0]);
        irq_lvl <= seed[0];
        emu_off_n_in <= seed[3];
        osc_drive_in <= seed[4];
        watchdog_clock_in <= seed[5];
        repeat (2 + seed[2:1]) @(posedge clock_in);
      end
      repeat (5) @(posedge clock_in);
      #1 chk(16'(n_req), 16'(n_exp));
      chk(16'(n_soc), 16'(n_exp));
      chk({osc_output_oe_n_out, osc_output_out}, {!emu_off_n_in, osc_drive_in});
      chk(irq_out, 16'(n_exp > 0));
      chk(ext_irq_two_pin_oe_n_out, 16'h1);
      rd_reg(spf_pkg::ADDR_IRQ_STAT, v);
      chk(v, n_exp > 0 ? 16'h0003 : 16'h0000);
      wr_reg(spf_pkg::ADDR_IRQ_MASK, 16'h0000);
      #1 chk(irq_out, 16'h0);
      wr_reg(spf_pkg::ADDR_IRQ_STAT, 16'h0003);
      wr_reg(spf_pkg::ADDR_IRQ_MASK, 16'h0003);
      #1 chk(irq_out, 16'h0);
    end
    wr_reg(spf_pkg::ADDR_SYS_CTRL, 16'h4000);
    #1 chk(clk_pin_out, watchdog_clock_in);
    wr_reg(spf_pkg::ADDR_GPIO_DIR, 16'h0008);
    wr_reg(spf_pkg::ADDR_GPIO_OUT, 16'h0008);
    wr_reg(spf_pkg::ADDR_CTRL, 16'h0020);
    #1 chk({clk_pin_oe_n_out, clk_pin_out}, 16'h1);
    rd_reg(4'hF, v);
    chk(v, 16'h0000);
    finish_test();
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    finish_test();
  end
endmodule : tb
